/* logic/wat_pkg.sv */
package wat_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] SETUP_IDX = 8'h34;
   localparam logic [7:0] CMD_IDX = 8'h35;
   localparam logic [7:0] STATUS_IDX = 8'h36;
   localparam logic [7:0] CTRL_IDX = 8'h37;
   localparam logic [21:0] ADDR_HI_ZERO = 22'h000000;

   // setup register fields
   localparam int OUT_BIT = 0;
   localparam int TIME_LSB = 1;
   localparam int EN_BIT = 3;
   localparam int TACT_BIT = 4;
   localparam int RAMT_BIT = 5;
   localparam logic [7:0] SETUP_RST = 8'h39;
   // control register fields
   localparam int TAP_BIT = 0;
   localparam logic TAP_RST = 1'b0;

   // command codes
   localparam logic [7:0] CLEAR_CODE = 8'h4E;
   localparam logic [7:0] DISABLE_CODE = 8'hB1;
   localparam logic [7:0] TRAP_ARM_CODE = 8'hD2;

   // fetch areas, inclusive bounds
   localparam logic [15:0] SFR_LO = 16'h0000;
   localparam logic [15:0] SFR_HI = 16'h003F;
   localparam logic [15:0] RAM_LO = 16'h0040;
   localparam logic [15:0] RAM_HI = 16'h083F;
   localparam logic [15:0] DBR_LO = 16'h0F80;
   localparam logic [15:0] DBR_HI = 16'h0FFF;

   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int RST_FC_PERIODS = 24;
   localparam int RST_TIME_NS = RST_FC_PERIODS * CLK_PERIOD_NS;
   localparam int RST_CYCLES = RST_TIME_NS / CLK_PERIOD_NS;
   localparam int RST_CNT_W = 5;
   localparam int DIV_W_DEFAULT = 23;
   localparam int FS_TAP_GAP = 8;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic [19:0] zero;
      logic osc_restart;
      logic rst_active;
      logic [1:0] bin;
      logic running;
      logic ram_live;
      logic ram_stage;
      logic trap_act;
      logic en;
      logic [1:0] tsel;
      logic out_sel;
   } wat_status_t;
endpackage

/* logic/wat_reg_if.sv */
`timescale 1ns/1ps
interface wat_reg_if;
   logic wr;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic [31:0] status;
   logic [31:0] ctrl;

   modport bus (
      output wr,
      output idx,
      output wdata,
      input status,
      input ctrl
   );
   modport core (
      input wr,
      input idx,
      input wdata,
      output status,
      output ctrl
   );
endinterface

/* logic/wat_ahb_slave.sv */
`timescale 1ns/1ps
module wat_ahb_slave (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // register side
   wat_reg_if.bus regs
);
   import wat_pkg::*;

   typedef struct packed {
      logic ph_wr;
      logic rd_pend;
      logic ph_ok;
      logic [7:0] ph_idx;
      logic [31:0] hrdata;
   } wat_ahb_state_t;

   wat_ahb_state_t s_q, s_d;

   function automatic logic mapped(input logic [7:0] idx);
      return idx == SETUP_IDX || idx == CMD_IDX || idx == STATUS_IDX || idx == CTRL_IDX;
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.ph_wr = 1'b0;
      if (s_q.rd_pend) begin
         // one wait state so a read sees a write that ended just before
         s_d.rd_pend = 1'b0;
         if (s_q.ph_ok && s_q.ph_idx == STATUS_IDX) begin
            s_d.hrdata = regs.status;
         end else if (s_q.ph_ok && s_q.ph_idx == CTRL_IDX) begin
            s_d.hrdata = regs.ctrl;
         end else begin
            s_d.hrdata = 32'h00000000;
         end
      end else if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ) begin
         s_d.ph_wr = hwrite_i;
         s_d.rd_pend = !hwrite_i;
         s_d.ph_idx = haddr_i[9:2];
         s_d.ph_ok = haddr_i[31:10] == ADDR_HI_ZERO && haddr_i[1:0] == 2'h0
                     && mapped(haddr_i[9:2]);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign regs.wr = s_q.ph_wr && s_q.ph_ok;
   assign regs.idx = s_q.ph_idx;
   assign regs.wdata = hwdata_i[7:0];
   assign hrdata_o = s_q.hrdata;
   assign hreadyout_o = !s_q.rd_pend;
   assign hresp_o = 1'b0;
endmodule

/* logic/wat_trap_decode.sv */
`timescale 1ns/1ps
module wat_trap_decode (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // fetch
   input wire logic fetch_valid_i,
   input wire logic [15:0] fetch_addr_i,
   input wire logic ram_trap_i,
   // result
   output logic hit_o
);
   import wat_pkg::*;

   typedef struct packed {
      logic hit;
   } wat_dec_state_t;

   wat_dec_state_t s_q, s_d;

   function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
      return a >= lo && a <= hi;
   endfunction

   always_comb begin
      s_d.hit = fetch_valid_i
                && (in_area(fetch_addr_i, SFR_LO, SFR_HI)
                    || in_area(fetch_addr_i, DBR_LO, DBR_HI)
                    || (ram_trap_i && in_area(fetch_addr_i, RAM_LO, RAM_HI)));
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hit_o = s_q.hit;
endmodule

/* logic/wat_top.sv */
// Behaviour
// - reset forces enable bit to 1; writing 1 also enables the watchdog
// - binary counter held cleared while the watchdog is disabled
// - action select 0: overflow raises the watchdog interrupt
// - watchdog interrupt is non-maskable, independent of the master flag
// - each new watchdog interrupt is raised at once, even while one is serviced
// - action select 1: overflow raises a reset request of 24/fc
// - reset in slow mode restarts the fast oscillator, still 24/fc long
// - ram trap select takes effect only after command D2H
// - fetch from special register or data buffer area always traps
// - watchdog and trap controls share the same two registers
// - trap action 0: trapped fetch raises the fetch trap interrupt
// - trap action 1: trapped fetch raises a reset request of 24/fc
// - fetch trap interrupt is non-maskable, independent of the master flag
// - each new fetch trap interrupt is raised at once, even during service
// - detection time select picks 2^25..2^19 fc or 2^17..2^11 fs periods
// - clear code resets only the binary counter, not the divider
// - disable code works only while the enable bit is already 0
// - counting pauses in stop, idle, sleep and warm-up, then resumes
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module wat_top #(
   parameter int DIV_W = wat_pkg::DIV_W_DEFAULT
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // cpu and clock system
   input wire logic fetch_valid_i,
   input wire logic [15:0] fetch_addr_i,
   input wire logic low_speed_mode_one_i,
   input wire logic lowclk_tick_i,
   input wire logic pause_i,
   // requests to the cpu and reset logic
   output logic watchdog_interrupt_o,
   output logic fetch_trap_interrupt_o,
   output logic reset_req_o,
   output logic hf_osc_restart_o
);
   import wat_pkg::*;

   typedef struct packed {
      logic en;
      logic [1:0] tsel;
      logic out_sel;
      logic trap_act;
      logic ram_stage;
      logic ram_live;
      logic running;
      logic tap_sel;
      logic [DIV_W-1:0] div;
      logic [1:0] bin;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic rst_slow;
      logic wdt_irq;
      logic trap_irq;
   } wat_state_t;

   wat_state_t s_q, s_d;
   logic [1:0] rsync_q;
   logic rst_n;
   logic trap_hit;
   logic src_tick;
   logic qtick;
   logic fire_reset;
   wat_status_t stat;

   wat_reg_if regs ();

   // hardware reset released through two flops
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rsync_q <= 2'h0;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end
   assign rst_n = rsync_q[1];

   wat_ahb_slave u_bus (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .hsel_i(hsel_i),
      .haddr_i(haddr_i),
      .htrans_i(htrans_i),
      .hwrite_i(hwrite_i),
      .hready_i(hready_i),
      .hwdata_i(hwdata_i),
      .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o),
      .regs(regs.bus)
   );

   wat_trap_decode u_trap (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .fetch_valid_i(fetch_valid_i),
      .fetch_addr_i(fetch_addr_i),
      .ram_trap_i(s_q.ram_live),
      .hit_o(trap_hit)
   );

   // true when div[top:0] are all ones, i.e. the next increment carries out
   function automatic logic low_ones(input logic [DIV_W-1:0] v, input int top);
      logic r;
      r = 1'b1;
      for (int i = 0; i < DIV_W; i++) begin
         if (i <= top && !v[i]) begin
            r = 1'b0;
         end
      end
      return r;
   endfunction

   // quarter-period tap: overflow needs four of these, hence 2 bits per step
   function automatic int tap_index(input logic [1:0] tsel, input logic use_fs);
      int t;
      t = DIV_W - 1 - 2 * int'(tsel);
      if (use_fs) begin
         t = t - FS_TAP_GAP;
      end
      return t;
   endfunction

   // slow clock drives the divider in slow mode or when the tap select asks
   assign src_tick = (low_speed_mode_one_i || s_q.tap_sel) ? lowclk_tick_i : 1'b1;
   assign qtick = !pause_i && src_tick
                  && low_ones(s_q.div, tap_index(s_q.tsel, low_speed_mode_one_i || s_q.tap_sel));

   always_comb begin
      s_d = s_q;
      s_d.wdt_irq = 1'b0;
      s_d.trap_irq = 1'b0;
      fire_reset = 1'b0;

      // divider is shared and never cleared by software
      if (!pause_i && src_tick) begin
         s_d.div = s_q.div + 1'b1;
      end

      if (!s_q.running) begin
         s_d.bin = 2'h0;
      end else if (qtick) begin
         s_d.bin = s_q.bin + 2'h1;
         if (s_q.bin == 2'h3) begin
            if (s_q.out_sel) begin
               fire_reset = 1'b1;
            end else begin
               s_d.wdt_irq = 1'b1;
            end
         end
      end

      if (trap_hit) begin
         if (s_q.trap_act) begin
            fire_reset = 1'b1;
         end else begin
            s_d.trap_irq = 1'b1;
         end
      end

      // one setup register carries both watchdog and trap fields
      if (regs.wr && regs.idx == SETUP_IDX) begin
         s_d.en = regs.wdata[EN_BIT];
         if (regs.wdata[EN_BIT]) begin
            s_d.running = 1'b1;
         end
         s_d.tsel = regs.wdata[TIME_LSB +: 2];
         // interrupt action, once chosen, cannot go back to reset
         s_d.out_sel = s_q.out_sel & regs.wdata[OUT_BIT];
         s_d.trap_act = regs.wdata[TACT_BIT];
         s_d.ram_stage = regs.wdata[RAMT_BIT];
      end

      if (regs.wr && regs.idx == CMD_IDX) begin
         unique case (regs.wdata)
            CLEAR_CODE: begin
               s_d.bin = 2'h0;
            end
            DISABLE_CODE: begin
               if (!s_q.en) begin
                  s_d.running = 1'b0;
                  s_d.bin = 2'h0;
               end
            end
            TRAP_ARM_CODE: begin
               s_d.ram_live = s_q.ram_stage;
            end
            default: begin
               // leaves a tick taken this cycle in place
               s_d.bin = s_d.bin;
            end
         endcase
      end

      if (regs.wr && regs.idx == CTRL_IDX) begin
         s_d.tap_sel = regs.wdata[TAP_BIT];
      end

      // pulse length is fixed; a fresh cause restarts it
      if (fire_reset) begin
         s_d.rst_cnt = RST_CNT_W'(RST_CYCLES);
         s_d.rst_slow = low_speed_mode_one_i;
      end else if (s_q.rst_cnt != '0) begin
         s_d.rst_cnt = s_q.rst_cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.en <= SETUP_RST[EN_BIT];
         s_q.running <= SETUP_RST[EN_BIT];
         s_q.tsel <= SETUP_RST[TIME_LSB +: 2];
         s_q.out_sel <= SETUP_RST[OUT_BIT];
         s_q.trap_act <= SETUP_RST[TACT_BIT];
         s_q.ram_stage <= SETUP_RST[RAMT_BIT];
         s_q.ram_live <= SETUP_RST[RAMT_BIT];
         s_q.tap_sel <= TAP_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // readable view of the write-only setup plus live state
   always_comb begin
      stat = '0;
      stat.out_sel = s_q.out_sel;
      stat.tsel = s_q.tsel;
      stat.en = s_q.en;
      stat.trap_act = s_q.trap_act;
      stat.ram_stage = s_q.ram_stage;
      stat.ram_live = s_q.ram_live;
      stat.running = s_q.running;
      stat.bin = s_q.bin;
      stat.rst_active = s_q.rst_cnt != '0;
      stat.osc_restart = s_q.rst_slow && s_q.rst_cnt != '0;
   end

   assign regs.status = 32'(stat);
   assign regs.ctrl = {31'h00000000, s_q.tap_sel};

   assign watchdog_interrupt_o = s_q.wdt_irq;
   assign fetch_trap_interrupt_o = s_q.trap_irq;
   assign reset_req_o = s_q.rst_cnt != '0;
   assign hf_osc_restart_o = s_q.rst_slow && s_q.rst_cnt != '0;
endmodule

/* bench/wat_top_asserts.sv */
`timescale 1ns/1ps
module wat_top_asserts
   import wat_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // bus
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // cpu side
   input wire logic fetch_valid_i,
   input wire logic [15:0] fetch_addr_i,
   input wire logic watchdog_interrupt_o,
   input wire logic fetch_trap_interrupt_o,
   input wire logic reset_req_o,
   input wire logic hf_osc_restart_o
);
   logic [7:0] rst_len_q;
   logic taken;
   logic fixed_hit;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_len_q <= 8'h00;
      end else begin
         rst_len_q <= reset_req_o ? rst_len_q + 8'h01 : 8'h00;
      end
   end
   assign taken = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
   assign fixed_hit = fetch_addr_i <= SFR_HI || (fetch_addr_i >= DBR_LO && fetch_addr_i <= DBR_HI);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   property p_fix_trap;
      fetch_valid_i && fixed_hit |-> ##2 (fetch_trap_interrupt_o || reset_req_o);
   endproperty
   a_fix_trap: assert property (p_fix_trap) else $error("fixed area fetch missed");
   property p_trap_cause;
      fetch_trap_interrupt_o |-> $past(fetch_valid_i, 2);
   endproperty
   a_trap_cause: assert property (p_trap_cause) else $error("trap without fetch");
   property p_wdt_pulse;
      watchdog_interrupt_o |=> !watchdog_interrupt_o [*8];
   endproperty
   a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse too long");
   property p_rst_len;
      $fell(reset_req_o) |-> rst_len_q == 8'h18;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset request length");
   property p_rst_hold;
      $rose(reset_req_o) |=> reset_req_o [*8];
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("reset request dropped");
   property p_osc;
      hf_osc_restart_o |-> reset_req_o;
   endproperty
   a_osc: assert property (p_osc) else $error("restart without reset");
   property p_rd_wait;
      taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_ready;
      taken && hwrite_i |=> hreadyout_o;
   endproperty
   a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
   property p_okay;
      hreadyout_o |-> !hresp_o;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");
endmodule

/* bench/wat_cpu_model.sv */
`timescale 1ns/1ps
module wat_cpu_model (
   // clock
   input wire logic clk_i,
   // requests from the unit
   input wire logic watchdog_interrupt_i,
   input wire logic fetch_trap_interrupt_i,
   // fetch and slow clock
   output logic fetch_valid_o,
   output logic [15:0] fetch_addr_o,
   output logic lowclk_tick_o
);
   logic [2:0] div_q = 3'h0;
   int n_wdt = 0;
   int n_trap = 0;
   initial begin
      fetch_valid_o = 1'b0;
      fetch_addr_o = 16'hFFFF;
      lowclk_tick_o = 1'b0;
   end
   // slow clock runs free, one tick per eight fast cycles
   always @(posedge clk_i) begin
      div_q <= div_q + 3'h1;
      lowclk_tick_o <= div_q == 3'h7;
   end
   // no master flag: every request is taken, nested ones too
   always @(posedge clk_i) begin
      if (watchdog_interrupt_i === 1'b1) n_wdt <= n_wdt + 1;
      if (fetch_trap_interrupt_i === 1'b1) n_trap <= n_trap + 1;
   end
   // released address flips so a stale value never decodes
   task fetch(input logic [15:0] a);
      @(posedge clk_i);
      fetch_valid_o <= 1'b1;
      fetch_addr_o <= a;
      @(posedge clk_i);
      fetch_valid_o <= 1'b0;
      fetch_addr_o <= ~a;
   endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
   import wat_pkg::*;
   logic clk, rstn, hsel, hwrite, slow, pause, hrdy, hresp, fv, tick, wdi, fti, rreq, osc, osc_seen;
   logic [1:0] htrans;
   logic [15:0] fa;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int n_mismatch = 0;
   int compares = 0;
   int n, len, base;
   wat_top #(.DIV_W(16)) u_wat_top (.sys_clk_i(clk), .resetn_i(rstn), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .fetch_valid_i(fv), .fetch_addr_i(fa), .low_speed_mode_one_i(slow), .lowclk_tick_i(tick),
      .pause_i(pause), .watchdog_interrupt_o(wdi), .fetch_trap_interrupt_o(fti),
      .reset_req_o(rreq), .hf_osc_restart_o(osc));
   wat_cpu_model u_wat_cpu_model (.clk_i(clk), .watchdog_interrupt_i(wdi),
      .fetch_trap_interrupt_i(fti), .fetch_valid_o(fv), .fetch_addr_o(fa), .lowclk_tick_o(tick));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task close_out;
      if (n_mismatch == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tmo;
      n_mismatch++;
      close_out;
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      // hready is taken as it stood just before each rising edge
      for (k = 0; k < 2; k++) begin
         n = 0;
         @(posedge clk);
         while (hrdy !== 1'b1) begin
            n++;
            if (n > 50) tmo;
            @(posedge clk);
         end
         if (k == 0) begin
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
         end
      end
      rd = hrdata;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask
   task fchk(input logic [15:0] a, input logic [31:0] exp);
      base = u_wat_cpu_model.n_trap;
      u_wat_cpu_model.fetch(a);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(u_wat_cpu_model.n_trap - base), exp);
   endtask
   task wait_irq(input int bound);
      n = 0;
      while (wdi !== 1'b1 && n < bound) begin
         @(negedge clk);
         n++;
      end
      if (n >= bound) tmo;
      @(negedge clk);
   endtask
   task wait_rst;
      n = 0;
      while (rreq !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) tmo;
      osc_seen = osc;
      len = 0;
      while (rreq === 1'b1 && len < 100) begin
         len++;
         @(negedge clk);
      end
   endtask
   task pause_check;
      base = u_wat_cpu_model.n_wdt;
      repeat (5000) @(posedge clk);
      chk(32'(u_wat_cpu_model.n_wdt - base), 32'h0);
   endtask
   task do_reset;
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      rstn = 1'b0;
      {hsel, hwrite, slow, pause} = 4'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      do_reset;
      rdc(32'hD8, 32'hFFF, 32'hF9);
      rdc(32'hD0, 32'hFFFFFFFF, 32'h0);
      rdc(32'h100, 32'hFFFFFFFF, 32'h0);
      wr(32'hDC, 32'h1);
      rdc(32'hDC, 32'hFFFFFFFF, 32'h1);
      wr(32'hDC, 32'h0);
      u_wat_cpu_model.fetch(16'h0010);
      wait_rst;
      chk(32'(len), 32'h18);
      chk({31'h0, osc_seen}, 32'h0);
      wr(32'hD0, 32'h2F);
      fchk(16'h0010, 32'h1);
      fchk(16'h0FFF, 32'h1);
      fchk(16'h0100, 32'h1);
      fchk(16'h0900, 32'h0);
      wr(32'hD0, 32'h0F);
      fchk(16'h0100, 32'h1);
      wr(32'hD4, 32'hD2);
      fchk(16'h0100, 32'h0);
      fchk(16'h003F, 32'h1);
      wr(32'hD0, 32'h0E);
      wr(32'hD4, 32'h4E);
      wait_irq(4200);
      chk({31'h0, n >= 3060 && n <= 4110}, 32'h1);
      wait_irq(4200);
      chk({31'h0, n >= 4088 && n <= 4104}, 32'h1);
      wr(32'hD0, 32'h0F);
      rdc(32'hD8, 32'h1, 32'h0);
      wr(32'hD4, 32'h55);
      wr(32'hD4, 32'hB1);
      rdc(32'hD8, 32'h88, 32'h88);
      wr(32'hD4, 32'h4E);
      pause <= 1'b1;
      pause_check;
      pause <= 1'b0;
      wait_irq(4200);
      chk({31'h0, n >= 3000 && n <= 4110}, 32'h1);
      wr(32'hD4, 32'h4E);
      wr(32'hD0, 32'h0E);
      wr(32'hD0, 32'h06);
      wr(32'hD4, 32'hB1);
      rdc(32'hD8, 32'h388, 32'h0);
      pause_check;
      wr(32'hD0, 32'h0E);
      rdc(32'hD8, 32'h88, 32'h88);
      do_reset;
      rdc(32'hD8, 32'hFFF, 32'hF9);
      slow <= 1'b1;
      wr(32'hD0, 32'h07);
      wait_rst;
      chk(32'(len), 32'h18);
      chk({31'h0, osc_seen}, 32'h1);
      close_out;
   end
endmodule
bind wat_top wat_top_asserts u_wat_top_asserts (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
   .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .fetch_valid_i(fetch_valid_i),
   .fetch_addr_i(fetch_addr_i), .watchdog_interrupt_o(watchdog_interrupt_o),
   .fetch_trap_interrupt_o(fetch_trap_interrupt_o), .reset_req_o(reset_req_o),
   .hf_osc_restart_o(hf_osc_restart_o));
